// >>> over_range_detector.sv
// over-range detector: magnitude of every raw sample, two threshold flags per period,
// flags packed into the lsb of the outgoing in-phase and quadrature words
// assumes raw samples and i/q words arrive synchronous to ref_clk with valid strobes
// Summary of operation
// RULE1: every raw 12-bit sample is checked before any decimation or mixing.
// RULE2: upper 8 magnitude bits compared against separate high and low thresholds.
// RULE3: offset binary to two's complement, 11-bit absolute value, -2048 saturates to 2047.
// RULE4: flag is 1 if any magnitude in the period reaches its threshold.
// RULE5: high flag rides with in-phase words, low flag with quadrature words.
// RULE6: period is 2 to the programmed exponent samples, 1 to 128.
// RULE7: code 2048 is zero input and yields magnitude zero.
// RULE8: flag sits in the word lsb, upper 15 bits hold the sample.
// RULE9: accumulators restart each period; outputs show the last completed period.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module over_range_detector
	import over_range_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// raw converter samples
	input wire logic [SAMPLE_W-1:0] rawSample,
	input wire logic sampleValid,
	// complex stream in
	input wire logic [IQ_W-1:0] iSample,
	input wire logic [IQ_W-1:0] qSample,
	input wire logic iqValid,
	// complex stream out
	output logic [IQ_W:0] iWord,
	output logic [IQ_W:0] qWord,
	output logic iqOutValid,
	// interrupt
	output logic irq
);

	// ==========================================================
	// registers
	logic [CMP_W-1:0] highRangeThreshold;
	logic [CMP_W-1:0] lowRangeThreshold;
	logic [EXP_W-1:0] rangePeriodExponent;
	logic [EVENT_W-1:0] irqStatus;
	logic [EVENT_W-1:0] irqMask;
	logic [31:0] readData;

	// ==========================================================
	// monitor state
	logic [COUNT_W-1:0] sampleCount;
	logic accHigh;
	logic accLow;
	logic highRangeFlag;
	logic lowRangeFlag;

	// ==========================================================
	// apb decode
	wire logic setupPhase = psel && !penable;
	wire logic writeStrobe = psel && penable && pwrite;
	wire logic hitThresh = (paddr == THRESH_OFFSET);
	wire logic hitPeriod = (paddr == PERIOD_OFFSET);
	wire logic hitFlags = (paddr == FLAGS_OFFSET);
	wire logic hitStatus = (paddr == IRQ_STATUS_OFFSET);
	wire logic hitMask = (paddr == IRQ_MASK_OFFSET);
	wire logic hitAny = hitThresh || hitPeriod || hitFlags || hitStatus || hitMask;
	wire logic [EVENT_W-1:0] clearBits = (writeStrobe && hitStatus) ? pwdata[EVENT_W-1:0] : '0;

	logic [31:0] next_readData;

	always_comb begin
		next_readData = 32'h0000_0000;
		if (hitThresh) begin
			next_readData[HIGH_THR_LSB +: CMP_W] = highRangeThreshold;
			next_readData[LOW_THR_LSB +: CMP_W] = lowRangeThreshold;
		end else if (hitPeriod) begin
			next_readData[PERIOD_EXP_LSB +: EXP_W] = rangePeriodExponent;
		end else if (hitFlags) begin
			next_readData[HIGH_BIT] = highRangeFlag;
			next_readData[LOW_BIT] = lowRangeFlag;
		end else if (hitStatus) begin
			next_readData[EVENT_W-1:0] = irqStatus;
		end else if (hitMask) begin
			next_readData[EVENT_W-1:0] = irqMask;
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hitAny;
	assign prdata = readData;

	// read data captured in the setup cycle, held through the access cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			readData <= 32'h0000_0000;
		end else if (setupPhase) begin
			readData <= next_readData;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			highRangeThreshold <= HIGH_THR_RESET;
			lowRangeThreshold <= LOW_THR_RESET;
			rangePeriodExponent <= PERIOD_EXP_RESET;
			irqMask <= IRQ_MASK_RESET;
		end else if (writeStrobe) begin
			if (hitThresh) begin
				highRangeThreshold <= pwdata[HIGH_THR_LSB +: CMP_W];
				lowRangeThreshold <= pwdata[LOW_THR_LSB +: CMP_W];
			end else if (hitPeriod) begin
				rangePeriodExponent <= pwdata[PERIOD_EXP_LSB +: EXP_W];
			end else if (hitMask) begin
				irqMask <= pwdata[EVENT_W-1:0];
			end
		end
	end

	// ==========================================================
	// magnitude
	wire logic [SAMPLE_W-1:0] signedSample = {~rawSample[SAMPLE_W-1], rawSample[SAMPLE_W-2:0]};
	wire logic isNegative = signedSample[SAMPLE_W-1];
	wire logic isMostNegative = (rawSample == CODE_MIN);
	wire logic [SAMPLE_W-1:0] negated = SAMPLE_W'(~signedSample + 12'h001);
	wire logic [MAG_W-1:0] sampleMag = isMostNegative ? MAG_SAT : // RULE3
		(isNegative ? negated[MAG_W-1:0] : signedSample[MAG_W-1:0]); // RULE3 RULE7
	wire logic [CMP_W-1:0] magTop = sampleMag[MAG_W-1 -: CMP_W]; // RULE2
	wire logic hitHigh = sampleValid && (magTop >= highRangeThreshold); // RULE1 RULE2 RULE4
	wire logic hitLow = sampleValid && (magTop >= lowRangeThreshold); // RULE1 RULE2 RULE4

	// ==========================================================
	// monitoring period
	wire logic [COUNT_W:0] periodLen = (COUNT_W+1)'(9'h001 << rangePeriodExponent); // RULE6
	wire logic [COUNT_W-1:0] periodMax = COUNT_W'(periodLen - 9'h001);
	// >= keeps the count bounded when the exponent is lowered mid-period
	wire logic periodEnd = sampleValid && (sampleCount >= periodMax); // RULE6

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sampleCount <= '0;
		end else if (periodEnd) begin
			sampleCount <= '0;
		end else if (sampleValid) begin
			sampleCount <= COUNT_W'(sampleCount + 8'h01);
		end
	end

	// ==========================================================
	// accumulators and flags
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			accHigh <= 1'b0;
			accLow <= 1'b0;
			highRangeFlag <= 1'b0;
			lowRangeFlag <= 1'b0;
		end else if (periodEnd) begin
			highRangeFlag <= accHigh || hitHigh; // RULE4 RULE9
			lowRangeFlag <= accLow || hitLow; // RULE4 RULE9
			accHigh <= 1'b0; // RULE9
			accLow <= 1'b0; // RULE9
		end else begin
			accHigh <= accHigh || hitHigh; // RULE4
			accLow <= accLow || hitLow; // RULE4
		end
	end

	// ==========================================================
	// interrupts: a new set wins over a clear in the same cycle
	wire logic [EVENT_W-1:0] newEvents = periodEnd ?
		{accLow || hitLow, accHigh || hitHigh} : '0;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irqStatus <= '0;
		end else begin
			irqStatus <= (irqStatus & ~clearBits) | newEvents;
		end
	end

	assign irq = |(irqStatus & irqMask);

	// ==========================================================
	// output stream
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			iWord <= '0;
			qWord <= '0;
			iqOutValid <= 1'b0;
		end else begin
			iqOutValid <= iqValid;
			if (iqValid) begin
				iWord <= {iSample, highRangeFlag}; // RULE5 RULE8
				qWord <= {qSample, lowRangeFlag}; // RULE5 RULE8
			end
		end
	end

	// ==========================================================
	// checks
	default clocking checkClk @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	mid_scale_zero_a: assert property ( // RULE7
		sampleValid && rawSample == CODE_MID |-> sampleMag == '0)
		else $error("mid-scale code did not give zero magnitude");

	negative_saturate_a: assert property ( // RULE3
		sampleValid && rawSample == CODE_MIN |-> sampleMag == MAG_SAT && hitHigh == 1'b1)
		else $error("most negative code did not saturate");

	full_scale_hit_a: assert property ( // RULE2
		sampleValid && rawSample == CODE_MAX |-> hitHigh && hitLow)
		else $error("full-scale sample missed a threshold");

	sample_seen_a: assert property ( // RULE1
		hitLow && !periodEnd |=> accLow)
		else $error("sample over low threshold was not accumulated");

	flag_set_a: assert property ( // RULE4
		periodEnd && hitHigh |=> highRangeFlag && irqStatus[HIGH_BIT])
		else $error("high flag not set after a hit");

	flag_clear_a: assert property ( // RULE4
		periodEnd && !accLow && !hitLow |=> !lowRangeFlag)
		else $error("low flag set without a hit");

	acc_restart_a: assert property ( // RULE9
		periodEnd |=> !accHigh && !accLow && sampleCount == '0)
		else $error("accumulators not restarted at period end");

	// high while the running period has seen no exponent write, so its length is exact
	logic steadyExp;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			steadyExp <= 1'b1;
		end else if (writeStrobe && hitPeriod) begin
			steadyExp <= 1'b0;
		end else if (periodEnd) begin
			steadyExp <= 1'b1;
		end
	end

	period_length_a: assert property ( // RULE6
		periodEnd && steadyExp
		|-> (32'(sampleCount) + 32'h1) == (32'h1 << rangePeriodExponent))
		else $error("period ended at the wrong sample count");

	i_word_pack_a: assert property ( // RULE8
		iqValid |=> iqOutValid && iWord[IQ_W:1] == $past(iSample)
		&& iWord[0] == $past(highRangeFlag))
		else $error("in-phase word packing wrong");

	q_word_pack_a: assert property ( // RULE5
		iqValid |=> qWord[IQ_W:1] == $past(qSample) && qWord[0] == $past(lowRangeFlag))
		else $error("quadrature word packing wrong");

	word_hold_a: assert property ( // RULE5
		!iqValid |=> $stable(iWord) && $stable(qWord) && !iqOutValid)
		else $error("output words changed without a new pair");

	flags_hold_a: assert property ( // RULE9
		!periodEnd |=> $stable(highRangeFlag) && $stable(lowRangeFlag))
		else $error("flags changed inside a period");

	acc_sticky_a: assert property ( // RULE4
		accHigh && !periodEnd |=> accHigh)
		else $error("high accumulator lost a hit inside a period");

	low_flag_set_a: assert property ( // RULE4
		periodEnd && hitLow |=> lowRangeFlag && irqStatus[LOW_BIT])
		else $error("low flag not set after a hit");

	high_flag_clear_a: assert property ( // RULE4
		periodEnd && !accHigh && !hitHigh |=> !highRangeFlag)
		else $error("high flag set without a hit");

	positive_mag_a: assert property ( // RULE3
		sampleValid && rawSample[SAMPLE_W-1] |-> sampleMag == rawSample[MAG_W-1:0])
		else $error("positive sample magnitude wrong");

	negative_mag_a: assert property ( // RULE3
		sampleValid && !rawSample[SAMPLE_W-1] && rawSample != CODE_MIN
		|-> sampleMag == MAG_W'(CODE_MID - rawSample))
		else $error("negative sample magnitude wrong");

	idle_no_hit_a: assert property ( // RULE1
		!sampleValid |-> !hitHigh && !hitLow && !periodEnd)
		else $error("threshold hit without a sample");

	high_reach_a: assert property ( // RULE2
		sampleValid && (32'(sampleMag) >= (32'(highRangeThreshold) << 3)) |-> hitHigh)
		else $error("magnitude at high threshold not flagged");

	low_below_a: assert property ( // RULE2
		sampleValid && (32'(sampleMag) < (32'(lowRangeThreshold) << 3)) |-> !hitLow)
		else $error("magnitude below low threshold flagged");

endmodule : over_range_detector

`default_nettype wire

// >>> over_range_detector_tb.sv
// self-checking bench: reference model of the monitor compared at every result
// assumes zero-wait apb answers and the sink model on the output stream
`timescale 1ns/1ps
`default_nettype none
module over_range_detector_tb;
	import over_range_pkg::*;
	// ==========================================================
	// signals and model state
	logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sampleValid = 0, iqValid = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, iqOutValid, irq, highFlag, lowFlag;
	logic [SAMPLE_W-1:0] rawSample = 12'h800;
	logic [IQ_W-1:0] iSample = 15'h0, qSample = 15'h0, expI, expQ;
	logic [IQ_W:0] iWord, qWord;
	logic [15:0] wordCount;
	logic [1:0] expF;
	int mismatches = 0, nCompared = 0, cnt = 0, words = 0, hThr = 255, lThr = 64;
	int nExp = 0, mask = 0, status = 0, flags = 0, acc = 0, newEv = 0;
	bit streaming = 0, expV = 0;
	logic [7:0] offs [5] = '{THRESH_OFFSET, PERIOD_OFFSET, FLAGS_OFFSET, IRQ_STATUS_OFFSET,
		IRQ_MASK_OFFSET};
	over_range_detector uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rawSample(rawSample), .sampleValid(sampleValid), .iSample(iSample),
		.qSample(qSample), .iqValid(iqValid), .iWord(iWord), .qWord(qWord),
		.iqOutValid(iqOutValid), .irq(irq));
	over_range_sink sink (.ref_clk(ref_clk), .rst(rst), .iWord(iWord), .qWord(qWord),
		.iqOutValid(iqOutValid), .highFlag(highFlag), .lowFlag(lowFlag), .wordCount(wordCount));
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	// ==========================================================
	// helpers
	function automatic int cmpMag(input logic [11:0] raw);
		int m;
		m = int'(raw) - 2048;
		if (m < 0) m = -m;
		if (m > 2047) m = 2047;
		return m >> 3;
	endfunction : cmpMag
	function automatic logic [11:0] pick();
		case ($urandom_range(4))
			0: return 12'h800 + 12'(hThr * 8);
			1: return 12'h801 - 12'(lThr * 8);
			2: return $urandom_range(1) ? CODE_MAX : CODE_MIN;
			3: return CODE_MID;
			default: return 12'($urandom);
		endcase
	endfunction : pick
	function automatic logic [31:0] regVal(input logic [7:0] a);
		case (a)
			THRESH_OFFSET: return 32'(hThr + lThr * 256);
			PERIOD_OFFSET: return 32'(nExp);
			FLAGS_OFFSET: return 32'(flags);
			IRQ_STATUS_OFFSET: return 32'(status);
			IRQ_MASK_OFFSET: return 32'(mask);
			default: return 32'h0;
		endcase
	endfunction : regVal
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		nCompared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic step();
		int m;
		@(posedge ref_clk);
		newEv = 0;
		expV = iqValid;
		if (iqValid) begin
			expI = iSample;
			expQ = qSample;
			expF = flags[1:0];
			words++;
		end
		if (sampleValid) begin
			m = cmpMag(rawSample);
			acc = acc | ((m >= hThr) ? 1 : 0) | ((m >= lThr) ? 2 : 0);
			if (cnt >= (1 << nExp) - 1) begin
				flags = acc;
				status = status | acc;
				newEv = acc;
				acc = 0;
				cnt = 0;
			end else begin
				cnt++;
			end
		end
		sampleValid <= streaming && $urandom_range(3) != 0;
		rawSample <= pick();
		iqValid <= streaming && $urandom_range(1) != 0;
		iSample <= 15'($urandom);
		qSample <= 15'($urandom);
	endtask : step
	task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d, input bit err);
		int k;
		logic [31:0] rdExp;
		step();
		rdExp = regVal(a);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		step();
		penable <= 1'b1;
		k = 0;
		do begin
			step();
			k++;
		end while (pready !== 1'b1 && k < 20);
		check("pready", 1, pready);
		check("pslverr", err, pslverr);
		if (!w) check("prdata", err ? 32'h0 : rdExp, prdata);
		if (w && !err) begin
			case (a)
				THRESH_OFFSET: begin
					hThr = d[7:0];
					lThr = d[15:8];
				end
				PERIOD_OFFSET: nExp = d[2:0];
				IRQ_STATUS_OFFSET: status = (status & ~int'(d[1:0])) | newEv;
				IRQ_MASK_OFFSET: mask = d[1:0];
				default: ;
			endcase
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic final_report();
		if (mismatches == 0 && nCompared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report
	// ==========================================================
	// output stream and interrupt compared mid-cycle
	always @(negedge ref_clk) begin
		if (!rst) begin
			check("irq", (status & mask) != 0, irq);
			check("iqOutValid", expV, iqOutValid);
			if (words > 0) begin
				check("iWord", {expI, expF[0]}, iWord);
				check("qWord", {expQ, expF[1]}, qWord);
				check("sinkFlags", expF, {lowFlag, highFlag});
			end
		end
	end
	initial begin
		#2000000;
		mismatches++;
		final_report();
	end
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(32'h14e11f72));
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) apb(0, offs[i], 32'h0, 0);
		apb(0, 8'h14, 32'h0, 1);
		apb(1, 8'h14, 32'hffffffff, 1);
		apb(1, FLAGS_OFFSET, 32'h3, 0);
		apb(0, FLAGS_OFFSET, 32'h0, 0);
		for (int n = 0; n < 8; n++) begin
			apb(1, THRESH_OFFSET, $urandom, 0);
			apb(1, PERIOD_OFFSET, 32'(7 - n), 0);
			apb(1, IRQ_MASK_OFFSET, $urandom, 0);
			streaming = 1;
			repeat (150) step();
			apb(0, IRQ_STATUS_OFFSET, 32'h0, 0);
			apb(1, IRQ_STATUS_OFFSET, 32'h3, 0);
			apb(0, FLAGS_OFFSET, 32'h0, 0);
			repeat (150) step();
			streaming = 0;
			repeat (3) step();
			apb(0, FLAGS_OFFSET, 32'h0, 0);
			apb(0, IRQ_STATUS_OFFSET, 32'h0, 0);
			apb(1, IRQ_STATUS_OFFSET, $urandom, 0);
			apb(0, IRQ_STATUS_OFFSET, 32'h0, 0);
		end
		check("wordCount", words, wordCount);
		final_report();
	end
endmodule : over_range_detector_tb
`default_nettype wire

// >>> over_range_pkg.sv
// constants for the over-range detector: register map, field layout, reset values
// assumes a 32-bit apb master and 12-bit offset-binary raw samples
package over_range_pkg;
	// ==========================================================
	// sample widths
	localparam int SAMPLE_W = 12;
	localparam int MAG_W = 11;
	localparam int CMP_W = 8;
	localparam int IQ_W = 15;
	localparam int EXP_W = 3;
	localparam int COUNT_W = 8;
	localparam logic [SAMPLE_W-1:0] CODE_MIN = 12'h000;
	localparam logic [SAMPLE_W-1:0] CODE_MAX = 12'hfff;
	localparam logic [SAMPLE_W-1:0] CODE_MID = 12'h800;
	localparam logic [MAG_W-1:0] MAG_SAT = 11'h7ff;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] THRESH_OFFSET = 8'h00;
	localparam logic [7:0] PERIOD_OFFSET = 8'h04;
	localparam logic [7:0] FLAGS_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0c;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;

	// ==========================================================
	// field positions
	localparam int HIGH_THR_LSB = 0;
	localparam int LOW_THR_LSB = 8;
	localparam int PERIOD_EXP_LSB = 0;
	localparam int HIGH_BIT = 0;
	localparam int LOW_BIT = 1;
	localparam int EVENT_W = 2;

	// ==========================================================
	// reset values
	localparam logic [CMP_W-1:0] HIGH_THR_RESET = 8'hff;
	localparam logic [CMP_W-1:0] LOW_THR_RESET = 8'h40;
	localparam logic [EXP_W-1:0] PERIOD_EXP_RESET = 3'h0;
	localparam logic [EVENT_W-1:0] IRQ_MASK_RESET = 2'h0;
endpackage : over_range_pkg

// >>> over_range_sink.sv
// downstream sink model: unpacks flags and counts words of the complex stream
// assumes registered words from the detector on ref_clk, qualified by iqOutValid
`timescale 1ns/1ps
`default_nettype none
module over_range_sink
	import over_range_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// complex stream
	input wire logic [IQ_W:0] iWord,
	input wire logic [IQ_W:0] qWord,
	input wire logic iqOutValid,
	// unpacked view
	output logic highFlag,
	output logic lowFlag,
	output logic [15:0] wordCount
);
	// ==========================================================
	// flags ride in the word lsb
	assign highFlag = iWord[0];
	assign lowFlag = qWord[0];
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wordCount <= 16'h0000;
		end else if (iqOutValid) begin
			wordCount <= wordCount + 16'h0001;
		end
	end
endmodule : over_range_sink
`default_nettype wire
